// ### include/amsc_pkg.sv
// package for the converter mode and shutdown control block
// assumes one master clock; modulator ticks come from an enable divider
//
// How it works
// - state field 11 convert, 10 standby, 0x shutdown
// - field is a wish; real state follows start-up
// - power-on reset leaves shutdown, field 00
// - conversion from shutdown waits 256 modulator periods
// - track real state and counter to shorten transitions
// - single channel rewrite 11 restarts running conversion
// - scan write 11 launches cycle, reads 11
// - scan rewrite 11 restarts sequence from step one
// - restart during gap shutdown adds full settling
// - result holds only complete, latest conversions
// - every end of conversion in convert state, not hit by a restart, flags three data-ready outputs
// - result survives transitions; cleared only by power-on reset and the full reset command
// - in conversion, restarts happen immediately
// - standby stops and resets converter, ready instantly
// - shutdown is immediate; later conversion fully settles
// - config byte 00 or code 1101 enters full shutdown
// - full shutdown disables supply monitoring
// - full shutdown keeps commands, result and settings
// - sequencer gap 00 never means full shutdown
// - full shutdown resets timers; state commands exit it
// - xx000000 with xx nonzero is partial shutdown
// - entering shutdown reloads counter to 256 at once
// - serial wake-ups from shutdown wait two clocks before counting; internal ones none

package amsc_pkg;

    // state request field encodings
    localparam logic [1:0] MODE_CONV = 2'h3;
    localparam logic [1:0] MODE_STBY = 2'h2;
    localparam logic [1:0] MODE_SHDN = 2'h0;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;

    // primary configuration byte layout and reset value
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_FULL_SHDN = 8'h00;
    localparam logic [5:0] CFG_LOW_ZERO = 6'h00;
    localparam logic [1:0] CFG_TOP_ZERO = 2'h0;

    // fast command codes; only full shutdown is fixed, others plain defaults
    localparam logic [3:0] FC_CONV = 4'ha;
    localparam logic [3:0] FC_STBY = 4'hb;
    localparam logic [3:0] FC_SHDN = 4'hc;
    localparam logic [3:0] FC_FULL_SHDN = 4'hd;
    localparam logic [3:0] FC_FULL_RESET = 4'he;

    // start-up timing
    localparam int SETUP_PERIODS = 256;   // modulator periods of settling
    localparam int SYNC_CLOCKS = 2;       // master clocks after a serial write
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_PERIODS);
    localparam logic [1:0] SYNC_LOAD = 2'(SYNC_CLOCKS);

    // result width
    localparam int RES_W = 24;
    localparam logic [RES_W-1:0] RES_RESET = 24'h000000;

    // converter state, one-hot
    typedef enum logic [3:0] {
        ST_SHDN   = 4'h1,
        ST_SETTLE = 4'h2,
        ST_STBY   = 4'h4,
        ST_CONV   = 4'h8
    } amsc_state_t;

endpackage : amsc_pkg

// ### include/amsc_timer_if.sv
// signals between the control core and its start-up timer
// assumes both ends run on the master clock
`timescale 1ns/1ps
`default_nettype none

interface amsc_timer_if;
    logic reload;       // hold counter at full settling value
    logic halt;         // reload every timer to its start (full shutdown)
    logic serial_kick;  // transition from a serial command
    logic done;         // counter reached zero
    logic [amsc_pkg::CNT_W-1:0] count;

    modport core (output reload, output halt, output serial_kick, input done, input count);
    modport timer (input reload, input halt, input serial_kick, output done, output count);
endinterface : amsc_timer_if

`default_nettype wire

// ### src/amsc_startup_timer.sv
// start-up timer: counts settling periods down to zero on modulator ticks
// assumes mod_tick is a one-cycle enable on the master clock
`timescale 1ns/1ps
`default_nettype none

module amsc_startup_timer (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic mod_tick,
    amsc_timer_if.timer tif
);

    logic [amsc_pkg::CNT_W-1:0] cnt_q;  // remaining modulator periods
    logic [amsc_pkg::CNT_W-1:0] cnt_d;
    logic [1:0] sync_q;                 // serial synchronisation wait
    logic [1:0] sync_d;
    logic run;                          // decrement allowed this cycle

    // no decrement while the serial wait runs or is being loaded; internal kicks have none
    assign run = mod_tick && (sync_q == 2'h0) && !tif.halt && !tif.serial_kick
                 && (cnt_q != {amsc_pkg::CNT_W{1'b0}});

    // reload wins, so shutdown always restores the full interval
    assign cnt_d = (tif.reload || tif.halt) ? amsc_pkg::SETUP_LOAD
                 : run ? cnt_q - amsc_pkg::CNT_W'(1)
                 : cnt_q;

    // a rewrite restarts only the wait, never the count itself
    // a kick that wakes from full shutdown still gets its wait
    assign sync_d = tif.serial_kick ? amsc_pkg::SYNC_LOAD
                  : tif.halt ? 2'h0
                  : (sync_q != 2'h0) ? sync_q - 2'h1
                  : sync_q;

    //////////////////////////////////////////////////////////////////////
    // counter registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= amsc_pkg::SETUP_LOAD;
            sync_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
            sync_q <= sync_d;
        end
    end

    assign tif.done = (cnt_q == {amsc_pkg::CNT_W{1'b0}});
    assign tif.count = cnt_d;   // next count, so a registered copy lines up with cnt_q

endmodule : amsc_startup_timer

`default_nettype wire

// ### src/amsc_top.sv
// converter mode and shutdown control: state request field, fast commands,
// start-up settling, restarts, result holding and low-power shutdown
// assumes command strobes and converter handshakes come from master-clock logic
`timescale 1ns/1ps
`default_nettype none

module amsc_top #(
    parameter int MOD_DIV = 4   // master clocks per modulator period
) (
    input wire logic clock,
    input wire logic rst_b,                 // power-on reset
    // serial command side
    input wire logic cfg_wr_valid,          // primary config byte write
    input wire logic [7:0] cfg_wr_data,
    input wire logic fast_cmd_valid,
    input wire logic [3:0] fast_cmd_code,
    input wire logic start_pulse_enable,
    input wire logic single_channel_mode,   // low selects scan sequencer
    // sequencer side
    input wire logic seq_gap_shutdown,      // sequencer forces 00 between cycles
    input wire logic seq_cycle_end,         // scan finished, no further cycle
    // converter side
    input wire logic conv_done,             // conversion completed
    input wire logic [amsc_pkg::RES_W-1:0] conv_data,
    // outputs
    output logic [7:0] primary_config_byte_q,
    output logic [1:0] mode_readback_q,
    output logic [3:0] adc_state_q,
    output logic converting_q,
    output logic converter_reset_q,
    output logic analog_on_q,
    output logic full_shutdown_q,
    output logic partial_shutdown_q,
    output logic supply_monitor_en_q,
    output logic conv_restart_q,
    output logic seq_restart_q,
    output logic start_pulse_q,
    output logic [2:0] data_ready_q,
    output logic [amsc_pkg::RES_W-1:0] conversion_result_q,
    output logic [amsc_pkg::CNT_W-1:0] startup_count_q
);

    //////////////////////////////////////////////////////////////////////
    // modulator clock divider

    localparam int DIV_W = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);

    logic [DIV_W-1:0] div_q;   // position inside one modulator period
    logic mod_tick;            // one master clock per modulator period

    assign mod_tick = (div_q == DIV_LAST);

    // free running; keeps no phase through full shutdown on purpose
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
        end else if (full_shutdown_q || mod_tick) begin
            div_q <= '0;   // timers stop and restart from zero
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    //////////////////////////////////////////////////////////////////////
    // command decode

    wire fc_conv = fast_cmd_valid && (fast_cmd_code == amsc_pkg::FC_CONV);
    wire fc_stby = fast_cmd_valid && (fast_cmd_code == amsc_pkg::FC_STBY);
    wire fc_shdn = fast_cmd_valid && (fast_cmd_code == amsc_pkg::FC_SHDN);
    wire fc_full = fast_cmd_valid && (fast_cmd_code == amsc_pkg::FC_FULL_SHDN);
    wire fc_reset = fast_cmd_valid && (fast_cmd_code == amsc_pkg::FC_FULL_RESET);
    wire fc_state = fc_conv || fc_stby || fc_shdn;   // state-changing fast command

    // fast state commands act as field writes of the matching value
    wire [1:0] fc_mode = fc_conv ? amsc_pkg::MODE_CONV
                       : fc_stby ? amsc_pkg::MODE_STBY
                       : amsc_pkg::MODE_SHDN;
    wire mode_write = (cfg_wr_valid || fc_state) && !fc_reset;
    wire [1:0] new_mode = fc_state ? fc_mode
                        : cfg_wr_data[amsc_pkg::MODE_MSB:amsc_pkg::MODE_LSB];
    wire write_conv = mode_write && (new_mode == amsc_pkg::MODE_CONV);

    // full shutdown only from a host write of 00 or the full shutdown command, never the sequencer gap
    wire enter_full = (cfg_wr_valid && (cfg_wr_data == amsc_pkg::CFG_FULL_SHDN))
                      || fc_full;
    wire leave_full = fc_state || fc_reset
                      || (cfg_wr_valid && (cfg_wr_data != amsc_pkg::CFG_FULL_SHDN));

    //////////////////////////////////////////////////////////////////////
    // configuration byte and full shutdown flag

    logic [7:0] cfg_d;
    logic full_d;

    // settings change only on writes, fast state commands and the full reset command; full shutdown leaves them alone
    always_comb begin
        cfg_d = primary_config_byte_q;
        if (fc_reset) begin
            cfg_d = amsc_pkg::CFG_RESET;
        end else if (cfg_wr_valid) begin
            cfg_d = cfg_wr_data;
        end else if (fc_state) begin
            cfg_d[amsc_pkg::MODE_MSB:amsc_pkg::MODE_LSB] = fc_mode;
        end
    end

    // entry wins when a write lands in the same cycle as an exit
    assign full_d = enter_full ? 1'b1 : leave_full ? 1'b0 : full_shutdown_q;

    // partial shutdown: low six bits clear, top two not both clear
    wire partial_d = (cfg_d[5:0] == amsc_pkg::CFG_LOW_ZERO)
                     && (cfg_d[7:6] != amsc_pkg::CFG_TOP_ZERO);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            primary_config_byte_q <= amsc_pkg::CFG_RESET;
            full_shutdown_q <= 1'b0;
            partial_shutdown_q <= 1'b0;
            supply_monitor_en_q <= 1'b1;
        end else begin
            primary_config_byte_q <= cfg_d;
            full_shutdown_q <= full_d;
            partial_shutdown_q <= partial_d && !full_d;
            supply_monitor_en_q <= !full_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // scan tracking

    logic scan_active_q;   // a scan cycle is under way
    logic gap_ignore_q;    // restart overrides the current gap
    wire gap_eff = scan_active_q && seq_gap_shutdown && !gap_ignore_q;
    logic gap_prev_q;      // previous gap level, for the internal wake-up

    // the sequencer's own wake-up starts the count with no sync wait
    wire gap_end = gap_prev_q && !gap_eff;

    // scan launch and restart both come from a write of 11 in scan mode
    wire scan_go = write_conv && !single_channel_mode;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scan_active_q <= 1'b0;
            gap_ignore_q <= 1'b0;
            gap_prev_q <= 1'b0;
        end else begin
            gap_prev_q <= gap_eff;
            if (scan_go) begin
                scan_active_q <= 1'b1;
            end else if (mode_write || fc_reset || seq_cycle_end || single_channel_mode) begin
                scan_active_q <= 1'b0;
            end
            // restart in a gap leaves the timer at full load: full settle
            if (scan_go && seq_gap_shutdown) begin
                gap_ignore_q <= 1'b1;
            end else if (!seq_gap_shutdown) begin
                gap_ignore_q <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // requested mode and start-up timer

    // decoded from the byte being taken, so shutdown lands at the taking edge
    wire [1:0] field = cfg_d[amsc_pkg::MODE_MSB:amsc_pkg::MODE_LSB];
    wire [1:0] req_mode = gap_eff ? amsc_pkg::MODE_SHDN : field;
    wire shut_req = full_d || !req_mode[amsc_pkg::MODE_MSB];

    amsc_timer_if tif ();

    assign tif.reload = shut_req;
    assign tif.halt = full_shutdown_q;
    // every write of 1x re-runs the sync wait, never the count
    assign tif.serial_kick = mode_write && new_mode[amsc_pkg::MODE_MSB];

    amsc_startup_timer u_timer (
        .clock(clock),
        .rst_b(rst_b),
        .mod_tick(mod_tick),
        .tif(tif)
    );

    //////////////////////////////////////////////////////////////////////
    // converter state machine

    amsc_pkg::amsc_state_t state_q;
    amsc_pkg::amsc_state_t state_d;

    // shutdown at once; otherwise settle until the counter is spent
    always_comb begin
        state_d = state_q;
        priority case (1'b1)
            shut_req: begin
                state_d = amsc_pkg::ST_SHDN;
            end
            !tif.done: begin
                state_d = amsc_pkg::ST_SETTLE;
            end
            (req_mode == amsc_pkg::MODE_CONV): begin
                state_d = amsc_pkg::ST_CONV;
            end
            default: begin
                state_d = amsc_pkg::ST_STBY;
            end
        endcase
    end

    // a single channel restart needs conversion already reached, else it is a plain start
    wire in_conv = (state_q == amsc_pkg::ST_CONV);
    wire conv_rst = write_conv && in_conv && single_channel_mode;
    wire seq_rst = scan_go;
    wire conv_entry = (state_d == amsc_pkg::ST_CONV) && !in_conv;
    wire start_ev = conv_entry || (in_conv && (conv_rst || seq_rst));

    // completion only counts while converting and not being restarted
    wire result_take = conv_done && in_conv && !conv_rst && !seq_rst;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= amsc_pkg::ST_SHDN;
        end else begin
            state_q <= state_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // status and strobe outputs

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            adc_state_q <= amsc_pkg::ST_SHDN;
            converting_q <= 1'b0;
            converter_reset_q <= 1'b1;
            analog_on_q <= 1'b0;
            mode_readback_q <= amsc_pkg::MODE_SHDN;
            conv_restart_q <= 1'b0;
            seq_restart_q <= 1'b0;
            start_pulse_q <= 1'b0;
            data_ready_q <= 3'h0;
            startup_count_q <= amsc_pkg::SETUP_LOAD;
        end else begin
            adc_state_q <= state_d;
            converting_q <= (state_d == amsc_pkg::ST_CONV);
            converter_reset_q <= (state_d != amsc_pkg::ST_CONV);
            analog_on_q <= (state_d != amsc_pkg::ST_SHDN);
            // scan reads 11 across the whole cycle, gaps included
            mode_readback_q <= (scan_active_q || scan_go) && !mode_write
                               ? amsc_pkg::MODE_CONV
                               : cfg_d[amsc_pkg::MODE_MSB:amsc_pkg::MODE_LSB];
            conv_restart_q <= conv_rst;
            seq_restart_q <= seq_rst;
            start_pulse_q <= start_pulse_enable && start_ev;
            data_ready_q <= {3{result_take}};
            startup_count_q <= tif.count;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // conversion result: kept through every transition and full shutdown

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            conversion_result_q <= amsc_pkg::RES_RESET;
        end else if (fc_reset) begin
            conversion_result_q <= amsc_pkg::RES_RESET;
        end else if (result_take) begin
            conversion_result_q <= conv_data;
        end
    end

endmodule : amsc_top

`default_nettype wire

// ### test/amsc_host_model.sv
// host side model: issues config byte writes and fast commands
// assumes requests change at the falling edge and last one clock
`timescale 1ns/1ps
`default_nettype none

module amsc_host_model (
    input wire logic clock,
    output logic cfg_wr_valid,
    output logic [7:0] cfg_wr_data,
    output logic fast_cmd_valid,
    output logic [3:0] fast_cmd_code
);
    ////////////////////////////////////////////////////////////////////////////
    // idle: no request; data lines stay static between requests, which also
    // keeps every input quiet in full shutdown
    initial begin
        cfg_wr_valid = 1'b0;
        cfg_wr_data = 8'h00;
        fast_cmd_valid = 1'b0;
        fast_cmd_code = 4'h0;
    end

    // one config byte write; the byte may be zero to reach full shutdown
    task automatic cfg_write(input logic [7:0] data);
        @(negedge clock);
        cfg_wr_valid = 1'b1;
        cfg_wr_data = data;
        @(negedge clock);
        cfg_wr_valid = 1'b0;
    endtask : cfg_write

    // one fast command, held for a single taking edge
    task automatic fast_cmd(input logic [3:0] code);
        @(negedge clock);
        fast_cmd_valid = 1'b1;
        fast_cmd_code = code;
        @(negedge clock);
        fast_cmd_valid = 1'b0;
    endtask : fast_cmd
endmodule : amsc_host_model

`default_nettype wire

// ### test/amsc_top_assertions.sv
// checker for the converter mode and shutdown control top ports
// assumes one master clock and the async active-low power-on reset
`timescale 1ns/1ps
`default_nettype none

module amsc_top_assertions #(
    parameter int MOD_DIV = 4   // kept in step with the design instance
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cfg_wr_valid,
    input wire logic [7:0] cfg_wr_data,
    input wire logic fast_cmd_valid,
    input wire logic [3:0] fast_cmd_code,
    input wire logic start_pulse_enable,
    input wire logic single_channel_mode,
    input wire logic conv_done,
    input wire logic [amsc_pkg::RES_W-1:0] conv_data,
    input wire logic [1:0] mode_readback_q,
    input wire logic [3:0] adc_state_q,
    input wire logic converting_q,
    input wire logic converter_reset_q,
    input wire logic full_shutdown_q,
    input wire logic partial_shutdown_q,
    input wire logic supply_monitor_en_q,
    input wire logic conv_restart_q,
    input wire logic start_pulse_q,
    input wire logic [2:0] data_ready_q,
    input wire logic [amsc_pkg::RES_W-1:0] conversion_result_q,
    input wire logic [amsc_pkg::CNT_W-1:0] startup_count_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // a lone serial write, so a same-cycle fast command cannot override it
    wire logic lone_wr = cfg_wr_valid && !fast_cmd_valid;
    wire logic wr_conv = lone_wr && (cfg_wr_data[1:0] == amsc_pkg::MODE_CONV);

    // a taken result: all three ready flags with the sampled word
    sequence s_taken;
        data_ready_q == 3'h7 && conversion_result_q == $past(conv_data);
    endsequence

    a_full_entry: assert property (lone_wr && cfg_wr_data == 8'h00 |=> full_shutdown_q)
        else $error("config byte zero did not enter full shutdown");
    a_fast_full: assert property (fast_cmd_valid && fast_cmd_code == 4'hd && !cfg_wr_valid
        |=> full_shutdown_q && startup_count_q == amsc_pkg::SETUP_LOAD)
        else $error("full shutdown command not honoured");
    a_monitor_off: assert property (supply_monitor_en_q != full_shutdown_q)
        else $error("supply monitor enable disagrees with full shutdown");
    a_partial_entry: assert property (lone_wr && cfg_wr_data[5:0] == 6'h00
        && cfg_wr_data[7:6] != 2'h0 |=> partial_shutdown_q && !full_shutdown_q)
        else $error("partial shutdown not entered");
    a_shdn_now: assert property (lone_wr && !cfg_wr_data[1]
        |=> adc_state_q == amsc_pkg::ST_SHDN && !converting_q)
        else $error("shutdown not immediate");
    a_shdn_count: assert property (adc_state_q == amsc_pkg::ST_SHDN
        && $past(adc_state_q) == amsc_pkg::ST_SHDN
        |-> startup_count_q == amsc_pkg::SETUP_LOAD)
        else $error("start-up count not held at full load in shutdown");
    a_settle_hold: assert property (adc_state_q == amsc_pkg::ST_SETTLE
        && startup_count_q != '0 |=> !converting_q)
        else $error("conversion began before settling ended");
    a_stby_reset: assert property (adc_state_q == amsc_pkg::ST_STBY
        |-> converter_reset_q && !converting_q)
        else $error("standby without converter reset");
    a_ready_take: assert property (conv_done && converting_q && !cfg_wr_valid
        && !fast_cmd_valid |=> s_taken)
        else $error("finished conversion not taken");
    a_ready_cause: assert property (data_ready_q != 3'h0
        |-> $past(conv_done) && $past(converting_q))
        else $error("data ready without a finished conversion");
    a_result_kept: assert property ($changed(conversion_result_q)
        |-> $past(conv_done) || ($past(fast_cmd_valid) && $past(fast_cmd_code) == 4'he))
        else $error("result changed without cause");
    a_restart_sc: assert property (converting_q && single_channel_mode && start_pulse_enable
        && wr_conv |=> conv_restart_q && start_pulse_q)
        else $error("single channel rewrite did not restart");
    a_scan_read: assert property (!single_channel_mode && wr_conv
        |=> mode_readback_q == amsc_pkg::MODE_CONV)
        else $error("scan launch not read back as convert");
endmodule : amsc_top_assertions

`default_nettype wire

bind amsc_top amsc_top_assertions #(.MOD_DIV(MOD_DIV)) u_chk (.clock(clock), .rst_b(rst_b),
    .cfg_wr_valid(cfg_wr_valid), .cfg_wr_data(cfg_wr_data), .fast_cmd_valid(fast_cmd_valid),
    .fast_cmd_code(fast_cmd_code), .start_pulse_enable(start_pulse_enable),
    .single_channel_mode(single_channel_mode), .conv_done(conv_done), .conv_data(conv_data),
    .mode_readback_q(mode_readback_q), .adc_state_q(adc_state_q), .converting_q(converting_q),
    .converter_reset_q(converter_reset_q), .full_shutdown_q(full_shutdown_q),
    .partial_shutdown_q(partial_shutdown_q), .supply_monitor_en_q(supply_monitor_en_q),
    .conv_restart_q(conv_restart_q), .start_pulse_q(start_pulse_q),
    .data_ready_q(data_ready_q), .conversion_result_q(conversion_result_q),
    .startup_count_q(startup_count_q));

// ### test/tb_top.sv
// testbench: host model drives commands, bench plays converter and sequencer
// assumes the design modulator divider is set to 1 to keep runs short
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clock, rst_b, spe, scm, gap, cyc_end, conv_done;
    logic [23:0] conv_data;
    wire logic cfg_wr_valid, fast_cmd_valid;
    wire logic [7:0] cfg_wr_data;
    wire logic [3:0] fast_cmd_code;
    logic [7:0] cfg_q;
    logic [1:0] rb_q;
    logic [3:0] st_q;
    logic conv_q, crst_q, an_q, full_q, part_q, mon_q, crs_q, srs_q, stp_q;
    logic [2:0] rdy_q;
    logic [23:0] res_q;
    logic [8:0] cnt_q;
    int num_errors = 0;
    int checks = 0;
    int n;

    amsc_host_model host (.clock(clock), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_data(cfg_wr_data),
        .fast_cmd_valid(fast_cmd_valid), .fast_cmd_code(fast_cmd_code));
    amsc_top #(.MOD_DIV(1)) dut (.clock(clock), .rst_b(rst_b), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_data(cfg_wr_data), .fast_cmd_valid(fast_cmd_valid),
        .fast_cmd_code(fast_cmd_code), .start_pulse_enable(spe), .single_channel_mode(scm),
        .seq_gap_shutdown(gap), .seq_cycle_end(cyc_end), .conv_done(conv_done),
        .conv_data(conv_data), .primary_config_byte_q(cfg_q), .mode_readback_q(rb_q),
        .adc_state_q(st_q), .converting_q(conv_q), .converter_reset_q(crst_q),
        .analog_on_q(an_q), .full_shutdown_q(full_q), .partial_shutdown_q(part_q),
        .supply_monitor_en_q(mon_q), .conv_restart_q(crs_q), .seq_restart_q(srs_q),
        .start_pulse_q(stp_q), .data_ready_q(rdy_q), .conversion_result_q(res_q),
        .startup_count_q(cnt_q));

    ////////////////////////////////////////////////////////////////////////////
    // 125 MHz master clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // compare one value; unknowns never match
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // count falling edges until converting, giving up after lim
    task automatic wait_conv(input int lim);
        n = 0;
        while (conv_q !== 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask : wait_conv

    // one finished conversion from the converter side
    task automatic finish_conv(input logic [23:0] d);
        @(negedge clock);
        conv_done = 1'b1;
        conv_data = d;
        @(negedge clock);
        conv_done = 1'b0;
        conv_data = ~d;   // data no longer valid, so show something else
    endtask : finish_conv

    task automatic end_of_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #80000;
        num_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b = 1'b0;
        {spe, scm, gap, cyc_end, conv_done} = 5'h18;
        conv_data = 24'h000000;
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        check({cfg_q, st_q, cnt_q, mon_q, an_q}, {8'h00, 4'h1, 9'h100, 2'h2});
        check(res_q, 24'h000000);
        // conversion from shutdown settles the full interval plus sync
        host.cfg_write(8'h03);
        check(st_q, amsc_pkg::ST_SETTLE);
        wait_conv(300);
        check(n >= 256 && n <= 262, 1'b1);
        finish_conv(24'h5a5a5a);
        check({rdy_q, res_q}, {3'h7, 24'h5a5a5a});
        @(negedge clock);
        check(rdy_q, 3'h0);
        // rewrite in single channel restarts with a fresh start pulse
        host.cfg_write(8'h03);
        check({crs_q, stp_q}, 2'h3);
        spe = 1'b0;
        host.cfg_write(8'h03);
        check({crs_q, stp_q}, 2'h2);
        spe = 1'b1;
        // standby halts and resets; conversion resumes without settling
        host.cfg_write(8'h02);
        check({st_q, crst_q, conv_q, an_q}, {4'h4, 3'h5});
        finish_conv(24'h123456);
        check({rdy_q, res_q}, {3'h0, 24'h5a5a5a});
        host.cfg_write(8'h03);
        wait_conv(4);
        check(conv_q, 1'b1);
        // scan mode: launch, gap shutdown, restart during the gap
        scm = 1'b0;
        host.cfg_write(8'h03);
        check(rb_q, 2'h3);
        gap = 1'b1;
        repeat (3) @(negedge clock);
        check({rb_q, full_q}, {2'h3, 1'b0});
        host.cfg_write(8'h03);
        check({srs_q, stp_q, cnt_q}, {2'h2, 9'h100});
        gap = 1'b0;
        cyc_end = 1'b1;
        @(negedge clock);
        cyc_end = 1'b0;
        scm = 1'b1;
        // shutdown with low bit set is immediate and keeps the result
        host.cfg_write(8'h01);
        check({st_q, conv_q, res_q}, {4'h1, 1'b0, 24'h5a5a5a});
        @(negedge clock);
        check(cnt_q, 9'h100);
        // low-power modes and every fast command
        host.cfg_write(8'hc0);
        check({part_q, full_q}, 2'h2);
        host.cfg_write(8'h00);
        check({full_q, mon_q, cfg_q, res_q}, {2'h2, 8'h00, 24'h5a5a5a});
        host.fast_cmd(amsc_pkg::FC_CONV);
        check({full_q, cfg_q[1:0], st_q}, {1'b0, 2'h3, 4'h2});
        host.fast_cmd(amsc_pkg::FC_STBY);
        check(cfg_q[1:0], 2'h2);
        host.fast_cmd(amsc_pkg::FC_SHDN);
        check({cfg_q[1:0], st_q}, {2'h0, 4'h1});
        host.fast_cmd(amsc_pkg::FC_FULL_SHDN);
        check({full_q, cnt_q}, {1'b1, 9'h100});
        host.fast_cmd(amsc_pkg::FC_FULL_RESET);
        check(res_q, 24'h000000);
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
